//--- logic/cpl_pins.sv
// Control pin logic: terminal count, bus fault, interrupts, reset straps, float
`timescale 1ns/1ps
// Functional notes
// R1 - Drive terminal count low at timer terminal count
// R2 - Hold low 1.5 cycles or until software
// R3 - Bus fault ends the current bus transaction
// R4 - Bus fault sampled only during reads/writes
// R5 - Faulted read raises a bus error exception
// R6 - Synced interrupt inputs are synchronized internally
// R7 - Outside agent synchronizes direct interrupt inputs
// R8 - Direct interrupts seen one cycle before synced
// R9 - Two interrupt pins give options during reset
// R10 - Options captured in last reset cycle
// R11 - Strap pins resume interrupt function after reset
// R12 - Float input tri-states listed outputs
// R13 - Outside source supplies double rate clock
module cpl_pins (
    // Clock and reset (clk is the double rate master clock)
    input  wire logic                            clk,
    input  wire logic                            srst,
    // Internal timer and bus control mode
    input  wire logic                            timer_terminal_hit,
    input  wire logic                            timer_sw_reset,
    input  wire logic                            tc_hold_mode,
    // Terminal count pin
    output logic                                 timer_terminal_count_n,
    output logic                                 timer_terminal_count_n_oe,
    // Bus transaction status from the bus interface unit
    input  wire logic                            xfer_active,
    input  wire logic                            xfer_is_read,
    input  wire logic                            bus_fault_in,
    output logic                                 xfer_abort,
    output logic                                 bus_error_exception,
    // Interrupt pins and interrupt levels seen by the core
    input  wire logic [cpl_pkg::DIRECT_IRQ_W-1:0] direct_irq_n,
    input  wire logic [cpl_pkg::SYNCED_IRQ_W-1:0] synced_irq_n,
    output logic [cpl_pkg::IRQ_W-1:0]            irq_level_n,
    // Reset configuration options
    output logic                                 address_show_cache_bypass_option,
    output logic                                 high_byte_first_option,
    // Board test float request and DMA release
    input  wire logic                            float_all_outputs_n,
    input  wire logic                            dma_release,
    output logic                                 bus_outputs_oe,
    // System clock and bus grant pins
    output logic                                 system_clock_out,
    output logic                                 system_clock_out_oe,
    input  wire logic                            bus_grant_req,
    output logic                                 bus_grant_out,
    output logic                                 bus_grant_out_oe
);
    import cpl_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    cpl_tc_state_t            tc_state;          // Terminal count output state
    logic [1:0]               tc_cnt;            // Ticks left in timed pulse
    logic                     phase;             // Processor clock phase
    logic [SYNCED_IRQ_W-1:0]  sirq_q1;           // Synchronizer stage one
    logic [SYNCED_IRQ_W-1:0]  sirq_q2;           // Synchronizer stage two
    logic [SYNCED_IRQ_W-1:0]  sirq_q3;           // Synchronizer stage three
    logic [SYNCED_IRQ_W-1:0]  sirq_f;            // Agreed synced level
    logic [DIRECT_IRQ_W-1:0]  dirq_d1;           // Direct pipeline stage one
    logic [DIRECT_IRQ_W-1:0]  dirq_d2;           // Direct pipeline stage two
    logic [2:0]               fault_q;           // Bus fault synchronizer
    logic                     fault_f;           // Agreed bus fault level
    logic                     fault_done;        // Fault already acted on this transfer
    logic [2:0]               float_q;           // Float request synchronizer
    logic                     float_active;      // Agreed float request
    logic                     grant_q;           // Registered bus grant
    logic                     next_fault_hit;    // Fault accepted this cycle

    // ****************************************************************
    // System clock
    // ****************************************************************
    // Half the master rate; the outside source runs clk at double rate R13
    always_ff @(posedge clk) begin
        if (srst) begin
            phase <= PHASE_RST;
        end else begin
            phase <= ~phase;
        end
    end

    // ****************************************************************
    // Terminal count output
    // ****************************************************************
    // Mode is looked at on the hit, so a mode change mid pulse is harmless
    always_ff @(posedge clk) begin
        if (srst) begin
            tc_state <= CPL_TC_IDLE;
            tc_cnt   <= TC_CNT_RST;
        end else begin
            case (tc_state)
                CPL_TC_IDLE: begin
                    if (timer_terminal_hit) begin                         // R1
                        tc_state <= tc_hold_mode ? CPL_TC_HOLD : CPL_TC_PULSE; // R2
                        tc_cnt   <= TC_PULSE_TICKS - 2'h1;
                    end
                end
                CPL_TC_PULSE: begin
                    // Three half cycles of the processor clock R2
                    if (tc_cnt == 2'h0) begin
                        tc_state <= CPL_TC_IDLE;
                    end else begin
                        tc_cnt <= tc_cnt - 2'h1;
                    end
                end
                CPL_TC_HOLD: begin
                    // A new hit in the same cycle keeps the output low
                    if (timer_sw_reset && !timer_terminal_hit) begin       // R2
                        tc_state <= CPL_TC_IDLE;
                    end
                end
                default: begin
                    tc_state <= CPL_TC_IDLE;
                    tc_cnt   <= TC_CNT_RST;
                end
            endcase
        end
    end

    // ****************************************************************
    // Bus fault
    // ****************************************************************
    // Pin synchronizer; stage one feeds stage two only
    always_ff @(posedge clk) begin
        fault_q <= {fault_q[1:0], bus_fault_in};
    end

    // Level counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (srst) begin
            fault_f <= 1'b0;
        end else if (fault_q[1] == fault_q[2]) begin
            fault_f <= fault_q[2];
        end
    end

    // Ignored outside reads and writes R4
    assign next_fault_hit = fault_f && xfer_active && !fault_done;

    // One abort per transfer; cleared when the transfer ends
    always_ff @(posedge clk) begin
        if (srst) begin
            fault_done          <= 1'b0;
            xfer_abort          <= 1'b0;
            bus_error_exception <= 1'b0;
        end else begin
            xfer_abort          <= next_fault_hit;                     // R3
            bus_error_exception <= next_fault_hit && xfer_is_read;     // R5
            if (!xfer_active) begin
                fault_done <= 1'b0;
            end else if (next_fault_hit) begin
                fault_done <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Interrupt inputs
    // ****************************************************************
    // Synced lines may change at any time; no reset so straps track R6
    always_ff @(posedge clk) begin
        sirq_q1 <= synced_irq_n;
        sirq_q2 <= sirq_q1;
        sirq_q3 <= sirq_q2;
    end

    // Agreed level of the synced lines R6
    always_ff @(posedge clk) begin
        if (sirq_q2 == sirq_q3) begin
            sirq_f <= sirq_q3;
        end
    end

    // Direct lines trust the outside agent, so two stages less R7
    always_ff @(posedge clk) begin
        dirq_d1 <= direct_irq_n;
        dirq_d2 <= dirq_d1;
    end

    // Lines read idle during reset, interrupt function after R11
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_level_n <= IRQ_N_RST;
        end else begin
            irq_level_n <= {dirq_d2, sirq_f};                          // R8
        end
    end

    // ****************************************************************
    // Reset configuration straps
    // ****************************************************************
    // Sampled every reset cycle, so the last reset cycle wins R10
    always_ff @(posedge clk) begin
        if (srst) begin
            address_show_cache_bypass_option <= ~dirq_d1[CFG_DIRECT_BIT]; // R9
            high_byte_first_option           <= ~sirq_q3[CFG_SYNCED_BIT]; // R9
        end
    end

    // ****************************************************************
    // Float request and output enables
    // ****************************************************************
    // Pin synchronizer for the board test request
    always_ff @(posedge clk) begin
        float_q <= {float_q[1:0], ~float_all_outputs_n};
    end

    // Agreed float level
    always_ff @(posedge clk) begin
        if (srst) begin
            float_active <= 1'b0;
        end else if (float_q[1] == float_q[2]) begin
            float_active <= float_q[2];
        end
    end

    // Registered bus grant
    always_ff @(posedge clk) begin
        if (srst) begin
            grant_q <= 1'b0;
        end else begin
            grant_q <= bus_grant_req;
        end
    end

    // Enables drop together while floated R12
    assign bus_outputs_oe            = !float_active && !dma_release;  // R12
    assign system_clock_out_oe       = !float_active;                  // R12
    assign timer_terminal_count_n_oe = !float_active;                  // R12
    assign bus_grant_out_oe          = !float_active;                  // R12

    // Pin values
    assign system_clock_out       = phase;
    assign bus_grant_out          = grant_q;
    assign timer_terminal_count_n = (tc_state == CPL_TC_IDLE);         // R1

endmodule : cpl_pins

//--- shared/cpl_pkg.sv
// Constants and types shared by the processor control pin logic
package cpl_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int DIRECT_IRQ_W = 3;   // Direct interrupt inputs, lines 5..3
    localparam int SYNCED_IRQ_W = 3;   // Synchronized interrupt inputs, lines 2..0
    localparam int IRQ_W        = DIRECT_IRQ_W + SYNCED_IRQ_W;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CFG_DIRECT_BIT = 0; // Direct line 3 carries address show option
    localparam int CFG_SYNCED_BIT = 0; // Synced line 0 carries byte order option

    // ****************************************************************
    // Timing
    // ****************************************************************
    // Terminal count pulse in tenths of a processor cycle (1.5 cycles)
    localparam int TC_PULSE_TENTHS     = 15;
    // Clock ticks per processor cycle: clk is the double rate clock
    localparam int TICKS_PER_CYCLE     = 2;
    // Pulse length in clk ticks, rounded up, never below one
    localparam int TC_PULSE_TICKS_INT  = (TC_PULSE_TENTHS * TICKS_PER_CYCLE + 9) / 10;
    localparam logic [1:0] TC_PULSE_TICKS =
        (TC_PULSE_TICKS_INT < 1) ? 2'h1 : TC_PULSE_TICKS_INT[1:0];

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [1:0]       TC_CNT_RST    = 2'h0;
    localparam logic [IRQ_W-1:0] IRQ_N_RST     = 6'h3f;   // All interrupts idle (high)
    localparam logic             CFG_RST       = 1'b0;
    localparam logic             PHASE_RST     = 1'b0;

    // ****************************************************************
    // Terminal count output states
    // ****************************************************************
    typedef enum logic [2:0] {
        CPL_TC_IDLE  = 3'b001,    // Output high
        CPL_TC_PULSE = 3'b010,    // Timed low pulse
        CPL_TC_HOLD  = 3'b100     // Low until software clears the timer
    } cpl_tc_state_t;

endpackage : cpl_pkg

//--- bench/cpl_pins_properties.sv
// Timing and ordering checks on the control pin logic ports
`timescale 1ns/1ps
module cpl_pins_properties (
    // Clock and reset
    input wire logic                              clk,
    input wire logic                              srst,
    // Terminal count
    input wire logic                              timer_terminal_hit,
    input wire logic                              timer_sw_reset,
    input wire logic                              tc_hold_mode,
    input wire logic                              timer_terminal_count_n,
    input wire logic                              timer_terminal_count_n_oe,
    // Bus fault
    input wire logic                              xfer_active,
    input wire logic                              xfer_abort,
    input wire logic                              bus_error_exception,
    // Interrupts and straps
    input wire logic [cpl_pkg::DIRECT_IRQ_W-1:0] direct_irq_n,
    input wire logic [cpl_pkg::SYNCED_IRQ_W-1:0] synced_irq_n,
    input wire logic [cpl_pkg::IRQ_W-1:0]        irq_level_n,
    input wire logic                              address_show_cache_bypass_option,
    input wire logic                              high_byte_first_option,
    // Float
    input wire logic                              float_all_outputs_n,
    input wire logic                              bus_outputs_oe,
    input wire logic                              system_clock_out_oe,
    input wire logic                              bus_grant_out_oe
);
    import cpl_pkg::*;
    // ****
    // Settling counter
    // ****
    logic [3:0] run_cnt;  // Edges since reset, saturating
    // Synchronizers carry no reset, so pipeline checks wait for them to refill
    always_ff @(posedge clk) begin
        if (srst) begin
            run_cnt <= 4'h0;
        end else if (run_cnt != 4'hf) begin
            run_cnt <= run_cnt + 4'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    chk_tc_starts: assert property (timer_terminal_hit && timer_terminal_count_n |=> !timer_terminal_count_n)
        else $error("terminal count not low after hit");
    chk_tc_timed: assert property ($fell(timer_terminal_count_n) && !tc_hold_mode |->
        !timer_terminal_count_n [*3] ##1 timer_terminal_count_n) else $error("timed pulse length wrong");
    chk_tc_held: assert property (!timer_terminal_count_n && tc_hold_mode && !timer_sw_reset
        |=> !timer_terminal_count_n) else $error("held terminal count released early");
    chk_abort_ctx: assert property (xfer_abort |-> $past(xfer_active) || $past(xfer_active, 2))
        else $error("abort outside a transfer");
    chk_abort_pulse: assert property (xfer_abort |=> !xfer_abort)
        else $error("abort longer than one cycle");
    chk_exc_pair: assert property (bus_error_exception |-> xfer_abort)
        else $error("exception without abort");
    chk_direct_lat: assert property (run_cnt > 4'h4 |-> irq_level_n[5:3] == $past(direct_irq_n, 3))
        else $error("direct interrupt latency wrong");
    chk_synced_follow: assert property ((run_cnt > 4'h7 && $stable(synced_irq_n)) [*6]
        |-> irq_level_n[2:0] == synced_irq_n) else $error("synced interrupt not followed");
    chk_opt_hold: assert property (!$past(srst) && !$past(srst, 2) |->
        $stable(address_show_cache_bypass_option) && $stable(high_byte_first_option)) else $error("option moved");
    chk_float_oe: assert property ((run_cnt > 4'h7 && !float_all_outputs_n) [*5] |->
        !(timer_terminal_count_n_oe || system_clock_out_oe || bus_grant_out_oe || bus_outputs_oe))
        else $error("output still driven while floated");
endmodule : cpl_pins_properties
bind cpl_pins cpl_pins_properties i_cpl_pins_properties (.*);

//--- bench/cpl_far_side.sv
// Model of the interrupt sources and the bus fault agent
`timescale 1ns/1ps
module cpl_far_side (
    // Clock and requested levels
    input  wire logic                             clk,
    input  wire logic [cpl_pkg::DIRECT_IRQ_W-1:0] want_direct_n,
    input  wire logic [cpl_pkg::SYNCED_IRQ_W-1:0] want_synced_n,
    input  wire logic                             want_fault,
    // Pins toward the block
    output logic      [cpl_pkg::DIRECT_IRQ_W-1:0] direct_irq_n,
    output logic      [cpl_pkg::SYNCED_IRQ_W-1:0] synced_irq_n,
    output logic                                  bus_fault_in
);
    import cpl_pkg::*;
    // Direct sources launch from the clock edge
    always_ff @(posedge clk) begin
        direct_irq_n <= want_direct_n;
    end
    // Synced sources land mid-cycle, unrelated to the clock
    assign #70 synced_irq_n = want_synced_n;
    // Fault agent is unclocked as well
    assign #31 bus_fault_in = want_fault;
endmodule : cpl_far_side

//--- bench/tb.sv
// Self-checking bench for the control pin logic
`timescale 1ns/1ps
module tb;
    import cpl_pkg::*;
    // ****
    // Nets
    // ****
    logic       clk, srst, timer_terminal_hit, timer_sw_reset, tc_hold_mode, xfer_active, xfer_is_read;
    logic       float_all_outputs_n, dma_release, bus_grant_req, want_fault, bus_fault_in, xfer_abort;
    logic       timer_terminal_count_n, timer_terminal_count_n_oe, bus_error_exception, bus_outputs_oe;
    logic       address_show_cache_bypass_option, high_byte_first_option, system_clock_out;
    logic       system_clock_out_oe, bus_grant_out, bus_grant_out_oe;
    logic [2:0] direct_irq_n, synced_irq_n, want_direct_n, want_synced_n;
    logic [5:0] irq_level_n;
    int         failures, checks;
    cpl_pins i_cpl_pins (.*);
    cpl_far_side i_cpl_far_side (.*);
    // Double rate master clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ****
    // Helpers and scenarios
    // ****
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic print_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    // Straps flip after two of the eight reset cycles; only the final levels may stick
    task automatic reset_straps(input logic d0, input logic s0);
        srst = 1'b1;
        want_direct_n = {2'h3, ~d0};
        want_synced_n = {2'h3, ~s0};
        step(2);
        want_direct_n = {2'h3, d0};
        want_synced_n = {2'h3, s0};
        step(6);
        srst = 1'b0;
        step(2);
        chk(8'(address_show_cache_bypass_option), 8'(!d0));
        chk(8'(high_byte_first_option), 8'(!s0));
        want_direct_n = 3'h2;
        want_synced_n = 3'h5;
        step(8);
        chk(8'(address_show_cache_bypass_option), 8'(!d0));
        chk(8'(irq_level_n), 8'h15);
    endtask : reset_straps
    // Timed pulse, hit while low ignored, hit again on release
    task automatic tc_timed;
        tc_hold_mode = 1'b0;
        timer_terminal_hit = 1'b1;
        for (int i = 0; i < 4; i++) begin
            step(1);
            timer_terminal_hit = (i == 1) || (i == 3);
            chk(8'(timer_terminal_count_n), 8'(i == 3));
        end
        step(1);
        timer_terminal_hit = 1'b0;
        chk(8'(timer_terminal_count_n), 8'h0);
        step(4);
    endtask : tc_timed
    task automatic tc_hold;
        tc_hold_mode = 1'b1;
        timer_terminal_hit = 1'b1;
        step(1);
        timer_terminal_hit = 1'b0;
        step(6);
        chk(8'(timer_terminal_count_n), 8'h0);
        timer_sw_reset = 1'b1;
        step(1);
        timer_sw_reset = 1'b0;
        chk(8'(timer_terminal_count_n), 8'h1);
        tc_hold_mode = 1'b0;
    endtask : tc_hold
    // Fault held for the whole transfer: checks which of abort and exception appear
    task automatic fault(input logic act, input logic rd, input logic [1:0] exp);
        logic [1:0] got;
        got = 2'h0;
        xfer_active = act;
        xfer_is_read = rd;
        want_fault = 1'b1;
        repeat (10) begin
            step(1);
            got = got | {xfer_abort, bus_error_exception};
        end
        chk(8'(got), 8'(exp));
        want_fault = 1'b0;
        xfer_active = 1'b0;
        step(4);
    endtask : fault
    // Both kinds change together; synced shows one cycle later
    task automatic irq_latency;
        int dd, ds;
        dd = 0;
        ds = 0;
        want_direct_n = 3'h5;
        want_synced_n = 3'h2;
        for (int i = 1; i < 10; i++) begin
            step(1);
            if (dd == 0 && irq_level_n[5:3] === 3'h5) dd = i;
            if (ds == 0 && irq_level_n[2:0] === 3'h2) ds = i;
        end
        // One processor cycle is two ticks of the double rate clock
        chk(8'(ds - dd), 8'(TICKS_PER_CYCLE));
    endtask : irq_latency
    task automatic float_test;
        logic sc;
        // System clock must flip on every master clock tick
        sc = system_clock_out;
        step(1);
        chk(8'(system_clock_out), 8'(!sc));
        bus_grant_req = 1'b1;
        float_all_outputs_n = 1'b0;
        step(6);
        chk(8'({timer_terminal_count_n_oe, system_clock_out_oe, bus_grant_out_oe, bus_outputs_oe}), 8'h0);
        float_all_outputs_n = 1'b1;
        dma_release = 1'b1;
        step(6);
        chk(8'({timer_terminal_count_n_oe, system_clock_out_oe, bus_grant_out_oe, bus_outputs_oe}), 8'he);
        chk(8'(bus_grant_out), 8'h1);
        dma_release = 1'b0;
        bus_grant_req = 1'b0;
    endtask : float_test
    initial begin
        {timer_terminal_hit, timer_sw_reset, tc_hold_mode, xfer_active, xfer_is_read} = 5'h0;
        {dma_release, bus_grant_req, want_fault} = 3'h0;
        float_all_outputs_n = 1'b1;
        reset_straps(1'b0, 1'b1);
        tc_timed();
        tc_hold();
        fault(1'b1, 1'b1, 2'h3);
        fault(1'b1, 1'b0, 2'h2);
        fault(1'b0, 1'b1, 2'h0);
        irq_latency();
        float_test();
        reset_straps(1'b1, 1'b0);
        print_verdict();
    end
    // Watchdog, far beyond the roughly 120 cycles the run needs
    initial begin
        repeat (2000) @(posedge clk);
        failures++;
        print_verdict();
    end
endmodule : tb
